// ### hdl/pbg_change_detect.v
// change comparator for the upper four pins
`include "pbg_regs.vh"
module pbg_change_detect #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_value,
  input  wire [WIDTH-1:0] port_direction,
  input  wire             port_read,
  input  wire             port_write,
  input  wire             port_write_move,
  output reg              mismatch
);
  reg  [WIDTH-1:0] reference;
  wire [WIDTH-1:0] eligible;
  wire [WIDTH-1:0] diff;
  wire             touch;
  assign eligible = `PBG_CHANGE_MASK & port_direction;
  assign diff  = (pin_value ^ reference) & eligible;
  assign touch = port_read | (port_write & ~port_write_move);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reference <= `PBG_LAT_RST;
      mismatch  <= 1'b0;
    end else begin
      if (touch)
        reference <= pin_value;
      mismatch <= touch ? 1'b0 : |diff;
    end
  end
endmodule

// ### hdl/pbg_port.v
// eight-pin bidirectional port with pull-ups and change flag
//
// Overview of operation
// - eight pins with direction, latch, read
// - direction one floats the driver
// - direction zero drives latch value
// - latch read returns latch not pins
// - one low bit enables all pull-ups
// - output pins lose their pull-up
// - resets leave pull-ups disabled
// - lower five analog, upper three digital
// - config bit picks lower pins default
// - upper four inputs only compared
// - reference captured on port read
// - ored mismatches set change flag
// - change flag wakes core from sleep
// - port access ends mismatch, except move
// - flag clear is ignored while mismatch persists
// - analog pins read as low
// - pins two, three shared with can
// - can transmit drives pin two
`include "pbg_regs.vh"
module pbg_port #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             por_event,
  input  wire             lower_pins_analog_default,
  input  wire             analog_cfg_write,
  input  wire [WIDTH-1:0] analog_cfg_data,
  input  wire             dir_write,
  input  wire [WIDTH-1:0] dir_data,
  input  wire             latch_write,
  input  wire [WIDTH-1:0] latch_data,
  input  wire             port_write,
  input  wire             port_write_move,
  input  wire [WIDTH-1:0] port_data,
  input  wire             port_read,
  input  wire             pullup_write,
  input  wire             pullup_data_n,
  input  wire             flag_clear,
  input  wire             core_sleeping,
  input  wire             can_enable,
  input  wire             can_transmit_out,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pin_oe,
  output reg  [WIDTH-1:0] pin_pullup,
  output reg  [WIDTH-1:0] port_b_pins,
  output reg  [WIDTH-1:0] port_output_latch,
  output reg  [WIDTH-1:0] port_direction,
  output reg  [WIDTH-1:0] analog_select,
  output reg              pullup_enable_n,
  output reg              port_change_flag,
  output reg              can_receive_in,
  output reg              wake_request
);
  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg  [WIDTH-1:0] next_latch;
  reg  [WIDTH-1:0] next_oe;
  reg  [WIDTH-1:0] next_out;
  wire [WIDTH-1:0] digital_in;
  wire             mismatch;

  assign digital_in = pin_in & ~analog_select;

  // the analog select default is taken after reset release and again after each por_event
  always @* begin
    next_state = state;
    case (state)
      `PBG_ST_IDLE: next_state = `PBG_ST_RUN;
      `PBG_ST_RUN:  next_state = por_event ? `PBG_ST_IDLE : `PBG_ST_RUN;
      default:      next_state = `PBG_ST_IDLE;
    endcase
  end

  always @* begin
    next_latch = port_output_latch;
    if (port_write)
      next_latch = port_data;
    else if (latch_write)
      next_latch = latch_data;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      always @* begin
        next_oe[i]  = ~port_direction[i];
        next_out[i] = port_output_latch[i];
        if (can_enable && i == `PBG_CAN_TX_BIT) begin
          next_oe[i]  = 1'b1;
          next_out[i] = can_transmit_out;
        end
      end
    end
  endgenerate

  pbg_change_detect #(
    .WIDTH(WIDTH)
  ) u_change (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .pin_value       (digital_in),
    .port_direction  (port_direction),
    .port_read       (port_read),
    .port_write      (port_write),
    .port_write_move (port_write_move),
    .mismatch        (mismatch)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state             <= `PBG_ST_IDLE;
      port_direction    <= `PBG_DIR_RST;
      port_output_latch <= `PBG_LAT_RST;
      pullup_enable_n   <= `PBG_PU_N_RST;
      analog_select     <= `PBG_ANALOG_MASK;
      port_change_flag  <= 1'b0;
      port_b_pins       <= {WIDTH{1'b0}};
      pin_out           <= {WIDTH{1'b0}};
      pin_oe            <= {WIDTH{1'b0}};
      pin_pullup        <= {WIDTH{1'b0}};
      can_receive_in    <= 1'b1;
      wake_request      <= 1'b0;
    end else begin
      state <= next_state;
      if (state == `PBG_ST_IDLE)
        analog_select <= lower_pins_analog_default ?
                         `PBG_ANALOG_MASK : {WIDTH{1'b0}};
      else if (analog_cfg_write)
        analog_select <= analog_cfg_data & `PBG_ANALOG_MASK;
      if (por_event)
        pullup_enable_n <= `PBG_PU_N_RST;
      else if (pullup_write)
        pullup_enable_n <= pullup_data_n;
      if (dir_write)
        port_direction <= dir_data;
      port_output_latch <= next_latch;
      port_b_pins <= digital_in;
      pin_out     <= next_out;
      pin_oe      <= next_oe;
      pin_pullup  <= {WIDTH{~pullup_enable_n}} & port_direction;
      can_receive_in <= pin_in[`PBG_CAN_RX_BIT];
      if (mismatch)
        port_change_flag <= 1'b1;
      else if (flag_clear)
        port_change_flag <= 1'b0;
      wake_request <= core_sleeping & (port_change_flag | mismatch);
    end
  end
endmodule

// ### hdl/pbg_regs.vh
// constants for the eight-pin port with change detection
`ifndef PBG_REGS_VH
`define PBG_REGS_VH
`define PBG_WIDTH        8
`define PBG_DIR_RST      8'hFF
`define PBG_LAT_RST      8'h00
`define PBG_PU_N_RST     1'b1
`define PBG_ANALOG_MASK  8'h1F
`define PBG_CHANGE_MASK  8'hF0
`define PBG_CAN_TX_BIT   2
`define PBG_CAN_RX_BIT   3
`define PBG_ST_IDLE      2'b01
`define PBG_ST_RUN       2'b10
`endif

// ### verification/pbg_pins_model.sv
// board side: keys hold undriven pins
module pbg_pins_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] key,
  output wire logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & key);
endmodule

// ### verification/pbg_port_asserts.sv
// assertions on pins, pull-ups and change flag
module pbg_port_asserts (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       por_event,
  input wire logic       dir_write,
  input wire logic [7:0] dir_data,
  input wire logic       flag_clear,
  input wire logic       core_sleeping,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] port_direction,
  input wire logic [7:0] analog_select,
  input wire logic       pullup_enable_n,
  input wire logic       port_change_flag,
  input wire logic       wake_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_asleep;
    core_sleeping && port_change_flag;
  endsequence
  // bit 2 left out: the transmitter may own it
  a_oe_from_dir: assert property (
    (pin_oe & 8'hFB) == (~$past(port_direction) & 8'hFB)) else $error("oe");
  a_pullup_mask: assert property (
    (pin_pullup & 8'hFB) == ({8{~$past(pullup_enable_n)}}
    & $past(port_direction) & 8'hFB)) else $error("pullup");
  a_sleep_wake: assert property (
    s_asleep |=> wake_request) else $error("wake");
  a_flag_holds: assert property (
    port_change_flag && !flag_clear && !por_event |=> port_change_flag)
    else $error("flag");
  a_analog_low: assert property (
    (port_b_pins & analog_select & $past(analog_select)) == 8'h00)
    else $error("analog");
  a_dir_load: assert property (
    dir_write |=> port_direction == $past(dir_data)) else $error("dir");
  a_dir_keep: assert property (
    !dir_write && !por_event |=> $stable(port_direction)) else $error("dk");
  a_por_pullup: assert property (
    por_event |=> pullup_enable_n) else $error("por");
endmodule
bind pbg_port pbg_port_asserts chk (.*);

// ### verification/pbg_port_tb.sv
// self-checking bench for the eight-pin port
module pbg_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, por_event = 0, dir_write = 0;
  logic latch_write = 0, port_write = 0, port_write_move = 0, port_read = 0;
  logic pullup_write = 0, pullup_data_n = 1, flag_clear = 0;
  logic core_sleeping = 0, can_enable = 0, can_transmit_out = 0;
  logic lower_pins_analog_default = 1, analog_cfg_write = 0;
  logic [7:0] analog_cfg_data = 0, dir_data = 0, latch_data = 0;
  logic [7:0] port_data = 0, key = 8'hFF;
  wire [7:0] pin_in, pin_out, pin_oe, pin_pullup, port_b_pins;
  wire [7:0] port_output_latch, port_direction, analog_select;
  wire pullup_enable_n, port_change_flag, can_receive_in, wake_request;
  int n_errors = 0, n_compared = 0;
  pbg_port dut (.*);
  pbg_pins_model pins (.*);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd_clr;
    port_read = 1; tick; port_read = 0; tick(2);
    flag_clear = 1; tick; flag_clear = 0; tick;
  endtask
  // latch read differs from pins; lower five read low as analog
  task automatic t_out;
    dir_data = 8'h0F; dir_write = 1; latch_data = 8'hA5; latch_write = 1;
    tick; dir_write = 0; latch_write = 0; port_data = 8'h3C; port_write = 1;
    tick; port_write = 0; key = 8'h55; tick(3);
    chk("latch", port_output_latch, 8'h3C);
    chk("oe", pin_oe, 8'hF0);
    chk("out", pin_out & pin_oe, 8'h30);
    chk("pins", port_b_pins, 8'h20);
    $display("out done");
  endtask
  task automatic t_pull;
    pullup_write = 1; pullup_data_n = 0; tick; pullup_write = 0; tick(3);
    chk("pu", pin_pullup, 8'h0F);
    por_event = 1; tick; por_event = 0; tick(3);
    chk("pu_n", pullup_enable_n, 8'h01);
    $display("pull done");
  endtask
  // bench reads the port only to end a mismatch, never polls
  task automatic t_change;
    dir_data = 8'hFF; dir_write = 1; key = 8'hFF; tick; dir_write = 0;
    tick(3); rd_clr; key = 8'hFE; tick(4);
    chk("low", port_change_flag, 8'h00);
    core_sleeping = 1; key = 8'h7E; tick(4);
    chk("flag", port_change_flag, 8'h01);
    chk("wake", wake_request, 8'h01);
    port_write_move = 1; port_write = 1; tick; port_write = 0;
    port_write_move = 0; flag_clear = 1; tick; flag_clear = 0; tick(2);
    chk("move", port_change_flag, 8'h01);
    rd_clr; core_sleeping = 0;
    chk("clr", port_change_flag, 8'h00);
    $display("change done");
  endtask
  // pin three left as input so the receive path sees the board
  task automatic t_can;
    can_enable = 1; can_transmit_out = 1; tick(3);
    chk("tx", {pin_oe[2], pin_out[2], can_receive_in}, 8'h07);
    can_transmit_out = 0; tick(3);
    chk("tx0", pin_out[2], 8'h00);
    $display("can done");
  endtask
  // digital default via config bit, then analog select written by hand
  task automatic t_analog;
    lower_pins_analog_default = 0; por_event = 1; tick; por_event = 0;
    tick(3);
    chk("ana_def", analog_select, 8'h00);
    analog_cfg_data = 8'hFF; analog_cfg_write = 1; tick;
    analog_cfg_write = 0; tick(3);
    chk("ana_wr", analog_select, 8'h1F);
    chk("ana_rd", port_b_pins, 8'h60);
    analog_cfg_data = 8'h00; analog_cfg_write = 1; tick;
    analog_cfg_write = 0; tick(3);
    chk("dig_rd", port_b_pins, 8'h7A);
    $display("analog done");
  endtask
  initial begin
    #5000;
    n_errors++;
    wrap_up;
  end
  initial begin
    tick(4);
    rst_n = 1;
    tick;
    chk("dir", port_direction, 8'hFF);
    t_out;
    t_pull;
    t_change;
    t_can;
    t_analog;
    wrap_up;
  end
endmodule
